//--- logic/clcd_consts.svh
// Constants of the character LCD display logic
`ifndef CLCD_CONSTS_SVH
`define CLCD_CONSTS_SVH
`define CLCD_CLK_NS       4
`define CLCD_EXEC_NS      39000
`define CLCD_SCAN_DIV     64
`define CLCD_BLINK_FRAMES 32
`define CLCD_EXT_DOTS     40
`define CLCD_SEGS         60
`define CLCD_COMS         34
`define CLCD_DUTY1        6'h11
`define CLCD_DUTY2        6'h21
`define CLCD_ICON_COM     6'h00
`define CLCD_COM_ONE      34'h0_0000_0001
`define CLCD_A_CMD        8'h00
`define CLCD_A_DATA       8'h04
`define CLCD_A_STAT       8'h08
`define CLCD_A_CFG        8'h0C
`define CLCD_CF_DEC       0
`define CLCD_CF_SIX       1
`define CLCD_CF_BE        2
`define CLCD_CF_CUR       3
`define CLCD_CF_BLK       4
`define CLCD_CF_INV       5
`define CLCD_CF_LN        6
`define CLCD_LN_ONE       2'h0
`define CLCD_LN_TWO       2'h1
`define CLCD_ST_BUSY      7
`define CLCD_ST_EXT       8
`define CLCD_ST_ISS       9
`define CLCD_CMD_TGT      8
`define CLCD_T_USER       2'h1
`define CLCD_T_ICON       2'h2
`define CLCD_CHAR_DEPTH   128
`define CLCD_USER_DEPTH   64
`define CLCD_ICON_DEPTH   16
`define CLCD_CHAR_MASK    7'h7F
`define CLCD_USER_MASK    7'h3F
`define CLCD_ICON_MASK    7'h0F
`define CLCD_L2_BASE      7'h40
`define CLCD_L4_STEP      7'h20
`define CLCD_L1_END       7'h4F
`define CLCD_L2_END       7'h27
`define CLCD_L4_END       7'h13
`define CLCD_ROW_LAST     3'h7
`define CLCD_TOP5         3'h4
`define CLCD_TOP6         3'h5
`define CLCD_B_UP         7
`define CLCD_B_LO         6
`endif

//--- logic/clcd_pkg.sv
// Types shared by the character LCD display logic
package clcd_pkg;
  typedef enum logic [1:0] {TGT_CHAR, TGT_USER, TGT_ICON} clcd_tgt_t;
  typedef enum logic {ST_IDLE, ST_BUSY} clcd_op_t;
endpackage

//--- logic/clcd_dot_if.sv
// Dot request and result between scan engine and dot calculator
`timescale 1ns/1ns
interface clcd_dot_if (
  input wire logic clk,
  input wire logic rst_b
);
  logic [7:0] byte_v;
  logic [2:0] dot;
  logic       six;
  logic       be;
  logic       phase;
  logic       cur_cell;
  logic       row_last;
  logic       cur_on;
  logic       cur_blink;
  logic       inv;
  logic       dot_on;
  modport src (output byte_v, dot, six, be, phase, cur_cell, row_last,
               output cur_on, cur_blink, inv, input dot_on);
  modport calc (input byte_v, dot, six, be, phase, cur_cell, row_last,
                input cur_on, cur_blink, inv, clk, rst_b,
                output dot_on);
endinterface // clcd_dot_if

//--- logic/clcd_dot.sv
// Dot calculator: pattern bit select, blink masks and cursor cell
`timescale 1ns/1ns
`include "clcd_consts.svh"
module clcd_dot (
  // Dot request and result
  clcd_dot_if.calc dot_if
);
  import clcd_pkg::*;

  logic [2:0] top;
  logic [2:0] sel;
  logic       pix;
  logic       blink;

  always_comb begin
    top = dot_if.six ? `CLCD_TOP6 : `CLCD_TOP5;
    // Leftmost dot comes from the top pattern bit
    sel = 3'(top - dot_if.dot);
    pix = dot_if.byte_v[sel];
    blink = dot_if.be && (dot_if.byte_v[`CLCD_B_UP] ||
            (dot_if.byte_v[`CLCD_B_LO] && sel == top));
    dot_if.dot_on = pix && !(blink && dot_if.phase);
    if (dot_if.cur_cell) begin
      if (dot_if.inv) dot_if.dot_on = !dot_if.dot_on;
      if (dot_if.cur_on && dot_if.row_last) dot_if.dot_on = 1'b1;
      if (dot_if.cur_blink && dot_if.phase) dot_if.dot_on = 1'b1;
    end
  end

  default clocking cb @(posedge dot_if.clk); endclocking
  default disable iff (!dot_if.rst_b);

  a_no_blink: assert property (
    !dot_if.be && !dot_if.cur_cell |-> dot_if.dot_on === pix)
    else $error("dot blinked with blink disabled");
  a_low_only: assert property (
    dot_if.be && !dot_if.byte_v[`CLCD_B_UP] && !dot_if.cur_cell &&
    sel != top |-> dot_if.dot_on == pix)
    else $error("low blink bit hit a non-top dot");
  a_all_blink: assert property (
    dot_if.be && dot_if.byte_v[`CLCD_B_UP] && dot_if.phase &&
    !dot_if.cur_cell |-> !dot_if.dot_on)
    else $error("upper blink bit failed to blank dot");
endmodule // clcd_dot

//--- logic/clcd_top.sv
// Character LCD display logic: APB registers, memories, common scan
`timescale 1ns/1ns
`include "clcd_consts.svh"
// Behaviour
// - Two-line mode shows addresses 00H-27H and 40H-67H.
// - Four-line mode shows 00H-13H, 20H-33H, 40H-53H, 60H-73H.
// - One-line six-dot mode shows the single line from 00H to 4FH.
// - One-line five-dot mode likewise ends its line at 4FH.
// - Extension enable high sends further dots out on extension pins.
// - Address counter loads from command, steps by one per data access.
// - Status read shows address counter on low seven bits.
// - After a data read the next byte is prefetched.
// - Cursor on/off, cell blink and inversion at the cursor cell.
// - Dots shift into 60-bit latch, copied out per 34-bit common scan.
// - One-line scans 17 commons; two or four lines scan 33.
// - Fixed glyph memory holds 240 patterns for codes 10H up.
// - Codes with upper nibble zero pick user glyph, bit 3 ignored.
// - Row blink bits act only with glyph blink enable set.
// - Five-dot: upper bit blinks bits 0-4, lower alone bit 4.
// - Six-dot: upper bit blinks bits 0-5, lower alone bit 5.
// - Icon memory shows on the first scanned common.
// - Icon bytes: two blink bits above six pattern bits.
// - Five-dot icons: bit 5 ignored, bits 4 down to 0.
// - Six-dot icons: bits 5 down to 0, 96 icons.
// - Icon blink 01 blinks top bit, 1x all, else none.
// - Instruction set select pin picks first or second command set.
// - Busy shows on bit 7 during operations; host waits for low.
// - Width select set means six-dot cells, clear five-dot.
module clcd_top #(
  parameter int BUSY_CYCLES  =
    (`CLCD_EXEC_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS,
  parameter int SCAN_DIV     = `CLCD_SCAN_DIV,
  parameter int BLINK_FRAMES = `CLCD_BLINK_FRAMES,
  parameter int EXT_DOTS     = `CLCD_EXT_DOTS
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Mode pins
  input  wire logic                   extension_driver_enable_i,
  input  wire logic                   instruction_set_select_i,
  // Panel drive and status
  output logic      [`CLCD_SEGS-1:0]  seg_o,
  output logic      [`CLCD_COMS-1:0]  com_o,
  output logic                        ext_data_o,
  output logic                        ext_shift_o,
  output logic                        ext_latch_o,
  output logic                        ext_alt_o,
  output logic                        busy_indicator_o
);
  import clcd_pkg::*;

  localparam int CW = $clog2(`CLCD_SEGS + EXT_DOTS);
  localparam int BW = $clog2(BUSY_CYCLES + 1);
  localparam int DW = $clog2(SCAN_DIV + 1);
  localparam int FCW = $clog2(BLINK_FRAMES + 1);
  localparam logic [CW-1:0] SEG_LAST = CW'(`CLCD_SEGS - 1);
  localparam logic [CW-1:0] EXT_LAST = CW'(`CLCD_SEGS + EXT_DOTS - 1);

  typedef struct packed {
    logic [2:0]            ext_s;
    logic                  ext_q;
    logic [2:0]            iss_s;
    logic                  iss_q;
    clcd_op_t              op;
    logic [BW-1:0]         bcnt;
    clcd_tgt_t             tgt;
    logic [6:0]            ac;
    logic [7:0]            hold;
    logic [7:0]            cfg;
    logic [31:0]           prdata;
    logic                  perr;
    logic [DW-1:0]         div;
    logic [CW-1:0]         col;
    logic [6:0]            ci;
    logic [2:0]            di;
    logic [5:0]            com;
    logic [`CLCD_SEGS-1:0] seg;
    logic [`CLCD_SEGS-1:0] outl;
    logic [`CLCD_COMS-1:0] comr;
    logic                  alt;
    logic [FCW-1:0]        fcnt;
    logic                  phase;
    logic                  ext_d;
    logic                  ext_sh;
    logic                  ext_la;
  } clcd_st_t;

  clcd_st_t   st_reg;
  clcd_st_t   st_next;
  logic [1:0] rst_sync_reg;
  logic       rst_b;
  logic [7:0] char_mem [`CLCD_CHAR_DEPTH];
  logic [7:0] user_mem [`CLCD_USER_DEPTH];
  logic [7:0] icon_mem [`CLCD_ICON_DEPTH];

  logic          busy;
  logic          setup;
  logic          ok_acc;
  logic          wr_cmd;
  logic          wr_dat;
  logic          rd_dat;
  logic          wr_cfg;
  clcd_tgt_t     new_tgt;
  logic [6:0]    new_ac;
  logic [6:0]    cmd_addr;
  logic [7:0]    memrd;
  logic          one;
  logic [5:0]    duty;
  logic [CW-1:0] last_col;
  logic [2:0]    wlast;
  logic [4:0]    r;
  logic [1:0]    line;
  logic [2:0]    row;
  logic [6:0]    base;
  logic [6:0]    lend;
  logic          lok;
  logic          cok;
  logic [6:0]    caddr;
  logic [7:0]    code;
  logic [7:0]    gbyte;

  clcd_dot_if dot_if (.clk(clk_i), .rst_b(rst_b));
  clcd_dot u_dot (.dot_if(dot_if.calc));

  function automatic logic [6:0] amask(clcd_tgt_t t);
    case (t)
      TGT_USER: amask = `CLCD_USER_MASK;
      TGT_ICON: amask = `CLCD_ICON_MASK;
      default:  amask = `CLCD_CHAR_MASK;
    endcase
  endfunction

  function automatic logic [6:0] step(logic [6:0] a, logic dec,
                                      clcd_tgt_t t);
    step = (dec ? a - 7'h1 : a + 7'h1) & amask(t);
  endfunction

  // Second set has no icon access: icon target falls to user glyphs
  function automatic clcd_tgt_t tdec(logic [1:0] f, logic set1);
    if (f == `CLCD_T_ICON && set1) tdec = TGT_ICON;
    else if (f == `CLCD_T_ICON || f == `CLCD_T_USER) tdec = TGT_USER;
    else tdec = TGT_CHAR;
  endfunction

  // Stand-in pattern set until the mask table is frozen
  function automatic logic [7:0] rom_row(logic [7:0] c, logic [2:0] rw);
    rom_row = {3'h0, c[4:0] ^ {2'h0, rw}};
  endfunction

  assign busy     = st_reg.op == ST_BUSY;
  assign setup    = psel_i && !penable_i;
  assign ok_acc   = psel_i && penable_i && !st_reg.perr;
  assign wr_cmd   = ok_acc && pwrite_i && paddr_i == `CLCD_A_CMD;
  assign wr_dat   = ok_acc && pwrite_i && paddr_i == `CLCD_A_DATA;
  assign rd_dat   = ok_acc && !pwrite_i && paddr_i == `CLCD_A_DATA;
  assign wr_cfg   = ok_acc && pwrite_i && paddr_i == `CLCD_A_CFG;
  assign cmd_addr = pwdata_i[6:0];
  assign new_tgt  = wr_cmd ? tdec(pwdata_i[`CLCD_CMD_TGT +: 2],
                                  st_reg.iss_q) : st_reg.tgt;
  assign new_ac   = wr_cmd ? cmd_addr & amask(new_tgt) :
                    (wr_dat || rd_dat) ?
                    step(st_reg.ac, st_reg.cfg[`CLCD_CF_DEC],
                         st_reg.tgt) : st_reg.ac;
  assign memrd    = new_tgt == TGT_USER ? user_mem[new_ac[5:0]] :
                    new_tgt == TGT_ICON ? icon_mem[new_ac[3:0]] :
                    char_mem[new_ac];

  // Which character cell and glyph row the scan is on
  always_comb begin
    one = st_reg.cfg[`CLCD_CF_LN +: 2] == `CLCD_LN_ONE;
    duty = one ? `CLCD_DUTY1 : `CLCD_DUTY2;
    last_col = st_reg.ext_q ? EXT_LAST : SEG_LAST;
    wlast = st_reg.cfg[`CLCD_CF_SIX] ? `CLCD_TOP6 : `CLCD_TOP5;
    r = 5'(st_reg.com - 6'h1);
    line = r[4:3];
    row = r[2:0];
    case (st_reg.cfg[`CLCD_CF_LN +: 2])
      `CLCD_LN_ONE: begin
        base = 7'h0;
        lend = `CLCD_L1_END;
        lok = line == 2'h0;
      end
      `CLCD_LN_TWO: begin
        base = line[0] ? `CLCD_L2_BASE : 7'h0;
        lend = `CLCD_L2_END;
        lok = !line[1];
      end
      default: begin
        base = 7'(line * `CLCD_L4_STEP);
        lend = `CLCD_L4_END;
        lok = 1'b1;
      end
    endcase
    // Cells past the line end read blank, whatever they hold
    cok = lok && st_reg.com != `CLCD_ICON_COM &&
          st_reg.ci <= lend;
    caddr = 7'(base + st_reg.ci);
    code = char_mem[caddr];
    gbyte = code[7:4] == 4'h0 ? user_mem[{code[2:0], row}] :
            rom_row(code, row);
    if (st_reg.com == `CLCD_ICON_COM)
      dot_if.byte_v = st_reg.ci < 7'(`CLCD_ICON_DEPTH) ?
                      icon_mem[st_reg.ci[3:0]] : 8'h0;
    else
      dot_if.byte_v = cok ? gbyte : 8'h0;
    dot_if.dot = st_reg.di;
    dot_if.six = st_reg.cfg[`CLCD_CF_SIX];
    dot_if.be = st_reg.cfg[`CLCD_CF_BE];
    dot_if.phase = st_reg.phase;
    dot_if.cur_cell = cok && st_reg.tgt == TGT_CHAR &&
                      caddr == st_reg.ac;
    dot_if.row_last = row == `CLCD_ROW_LAST;
    dot_if.cur_on = st_reg.cfg[`CLCD_CF_CUR];
    dot_if.cur_blink = st_reg.cfg[`CLCD_CF_BLK];
    dot_if.inv = st_reg.cfg[`CLCD_CF_INV];
  end

  always_comb begin
    st_next = st_reg;
    st_next.ext_s = {st_reg.ext_s[1:0], extension_driver_enable_i};
    st_next.iss_s = {st_reg.iss_s[1:0], instruction_set_select_i};
    if (st_reg.ext_s[1] == st_reg.ext_s[2])
      st_next.ext_q = st_reg.ext_s[2];
    if (st_reg.iss_s[1] == st_reg.iss_s[2])
      st_next.iss_q = st_reg.iss_s[2];
    st_next.ext_sh = 1'b0;
    st_next.ext_la = 1'b0;
    if (busy) begin
      if (st_reg.bcnt == '0) st_next.op = ST_IDLE;
      else st_next.bcnt = st_reg.bcnt - 1'b1;
    end
    // Answer is prepared in setup so read data leaves a flip-flop
    if (setup) begin
      st_next.prdata = '0;
      st_next.perr = 1'b0;
      case (paddr_i)
        `CLCD_A_CMD: st_next.perr = !pwrite_i || busy;
        `CLCD_A_DATA: begin
          st_next.perr = busy;
          st_next.prdata[7:0] = st_reg.hold;
        end
        `CLCD_A_STAT: begin
          st_next.perr = pwrite_i;
          st_next.prdata[6:0] = st_reg.ac;
          st_next.prdata[`CLCD_ST_BUSY] = busy;
          st_next.prdata[`CLCD_ST_EXT] = st_reg.ext_q;
          st_next.prdata[`CLCD_ST_ISS] = st_reg.iss_q;
        end
        `CLCD_A_CFG: st_next.prdata[7:0] = st_reg.cfg;
        default: st_next.perr = 1'b1;
      endcase
    end
    if (wr_cfg) st_next.cfg = pwdata_i[7:0];
    if (wr_cmd || wr_dat || rd_dat) begin
      st_next.op = ST_BUSY;
      st_next.bcnt = BW'(BUSY_CYCLES - 1);
      st_next.tgt = new_tgt;
      st_next.ac = new_ac;
      st_next.hold = memrd;
    end
    if (st_reg.div == '0) begin
      st_next.div = DW'(SCAN_DIV - 1);
      if (st_reg.col <= SEG_LAST) begin
        st_next.seg = {st_reg.seg[`CLCD_SEGS-2:0], dot_if.dot_on};
      end else begin
        st_next.ext_d = dot_if.dot_on;
        st_next.ext_sh = 1'b1;
      end
      if (st_reg.di == wlast) begin
        st_next.di = '0;
        st_next.ci = st_reg.ci + 7'h1;
      end else begin
        st_next.di = st_reg.di + 3'h1;
      end
      if (st_reg.col >= last_col) begin
        st_next.col = '0;
        st_next.ci = '0;
        st_next.di = '0;
        st_next.outl = st_next.seg;
        st_next.comr = `CLCD_COM_ONE << st_reg.com;
        st_next.ext_la = st_reg.ext_q;
        if (st_reg.com >= duty - 6'h1) begin
          st_next.com = `CLCD_ICON_COM;
          st_next.alt = !st_reg.alt;
          if (st_reg.fcnt == FCW'(BLINK_FRAMES - 1)) begin
            st_next.fcnt = '0;
            st_next.phase = !st_reg.phase;
          end else begin
            st_next.fcnt = st_reg.fcnt + 1'b1;
          end
        end else begin
          st_next.com = st_reg.com + 6'h1;
        end
      end else begin
        st_next.col = st_reg.col + 1'b1;
      end
    end else begin
      st_next.div = st_reg.div - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_b = rst_sync_reg[1];

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) st_reg <= '0;
    else st_reg <= st_next;
  end

  // Memories keep no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_dat) begin
      case (st_reg.tgt)
        TGT_USER: user_mem[st_reg.ac[5:0]] <= pwdata_i[7:0];
        TGT_ICON: icon_mem[st_reg.ac[3:0]] <= pwdata_i[7:0];
        default:  char_mem[st_reg.ac] <= pwdata_i[7:0];
      endcase
    end
  end

  assign pready_o         = 1'b1;
  assign prdata_o         = st_reg.prdata;
  assign pslverr_o        = st_reg.perr;
  assign seg_o            = st_reg.outl;
  assign com_o            = st_reg.comr;
  assign ext_data_o       = st_reg.ext_d && st_reg.ext_q;
  assign ext_shift_o      = st_reg.ext_sh;
  assign ext_latch_o      = st_reg.ext_la;
  assign ext_alt_o        = st_reg.alt && st_reg.ext_q;
  assign busy_indicator_o = busy;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  sequence s_data_op;
    ok_acc && paddr_i == `CLCD_A_DATA;
  endsequence

  a_busy_hold: assert property (s_data_op |=> busy [*8])
    else $error("busy dropped too early");
  a_busy_refuse: assert property (
    setup && busy && paddr_i == `CLCD_A_DATA |=> st_reg.perr)
    else $error("access while busy not refused");
  a_ac_inc: assert property (
    (s_data_op and !st_reg.cfg[`CLCD_CF_DEC]) |=>
    st_reg.ac == ((7'($past(st_reg.ac)) + 7'h1) & amask(st_reg.tgt)))
    else $error("address counter did not increment");
  a_ac_dec: assert property (
    (s_data_op and st_reg.cfg[`CLCD_CF_DEC]) |=>
    st_reg.ac == ((7'($past(st_reg.ac)) - 7'h1) & amask(st_reg.tgt)))
    else $error("address counter did not decrement");
  a_ac_load: assert property (
    wr_cmd |=> st_reg.ac == ($past(cmd_addr) & amask(st_reg.tgt)))
    else $error("address counter not loaded");
  a_status_ac: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == `CLCD_A_STAT |->
    prdata_o[6:0] == st_reg.ac &&
    prdata_o[`CLCD_ST_BUSY] == $past(busy))
    else $error("status read wrong");
  a_prefetch: assert property (
    rd_dat && st_reg.tgt == TGT_CHAR |=>
    st_reg.hold === char_mem[st_reg.ac])
    else $error("next byte not prefetched");
  a_frame_wrap: assert property (
    st_reg.div == '0 && st_reg.col >= last_col &&
    st_reg.com == duty - 6'h1 |=>
    st_reg.com == `CLCD_ICON_COM && st_reg.alt != $past(st_reg.alt))
    else $error("scan did not wrap at duty end");
  a_com_onehot: assert property ($onehot0(com_o))
    else $error("more than one common selected");
  a_range_two: assert property (
    cok && st_reg.cfg[`CLCD_CF_LN +: 2] == `CLCD_LN_TWO |->
    caddr <= `CLCD_L2_END ||
    (caddr >= `CLCD_L2_BASE && caddr <= `CLCD_L2_BASE + `CLCD_L2_END))
    else $error("two-line cell outside range");
endmodule // clcd_top

//--- bench/clcd_host.sv
// Host model: APB master polling the busy bit between operations
`timescale 1ns/1ns
`include "clcd_consts.svh"
module clcd_host (
  // Clock
  input  wire logic        clk_i,
  // APB master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
  end
  // Request held until pready seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    do xfer(1'b0, `CLCD_A_STAT, 32'h0, q, e); while (q[7] !== 1'b0);
    // Spacing after busy low before the next operation
    @(posedge clk_i);
  endtask
endmodule // clcd_host

//--- bench/clcd_top_tb.sv
// Testbench of the character LCD display logic
`timescale 1ns/1ns
`include "clcd_consts.svh"
`define CHK(nm, ex, gt) \
  begin \
    checks_done++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("mismatch %s exp %h got %h", nm, ex, gt); \
    end \
  end
module clcd_top_tb;
  import clcd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ext_en = 1'b0;
  logic        iss = 1'b1;
  logic [33:0] com;
  logic        ext_shift;
  logic        ext_latch;
  logic        busy_pin;
  int          n_latch = 0;
  int          l0;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_hi = 0;
  int          n_shift = 0;
  int          h0, s0;
  logic        bad_hot = 1'b0;

  always #2 clk = ~clk;

  clcd_host i_host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  // Short counts keep the scan frames inside the run
  clcd_top #(.BUSY_CYCLES(16), .SCAN_DIV(1), .BLINK_FRAMES(2)) i_dut (
    .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .extension_driver_enable_i(ext_en),
    .instruction_set_select_i(iss), .seg_o(), .com_o(com),
    .ext_data_o(), .ext_shift_o(ext_shift), .ext_latch_o(ext_latch),
    .ext_alt_o(), .busy_indicator_o(busy_pin));

  always @(posedge clk) begin
    if (com[33:18] !== 16'h0000) n_hi <= n_hi + 1;
    if (!$onehot0(com)) bad_hot <= 1'b1;
    if (ext_shift === 1'b1) n_shift <= n_shift + 1;
    if (ext_latch === 1'b1) n_latch <= n_latch + 1;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ee, input logic w);
    logic [31:0] q;
    logic        e;
    i_host.xfer(1'b1, a, d, q, e);
    `CHK("wr_err", ee, e)
    if (w) i_host.wait_idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input logic ee, input logic w);
    logic [31:0] q;
    logic        e;
    i_host.xfer(1'b0, a, 32'h0, q, e);
    `CHK("rd_err", ee, e)
    if (!ee) `CHK("rdata", ex, q)
    if (w) i_host.wait_idle();
  endtask
  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Pin synchronisers need a few edges before status is settled
    repeat (6) @(posedge clk);
    rd(`CLCD_A_STAT, 32'h0000_0200, 0, 0);
    rd(`CLCD_A_CFG, 32'h0000_0000, 0, 0);
    endt("reset");
    wr(`CLCD_A_CMD, 32'h0000_0010, 0, 1);
    wr(`CLCD_A_DATA, 32'h0000_005A, 0, 1);
    wr(`CLCD_A_DATA, 32'h0000_00A5, 0, 1);
    rd(`CLCD_A_STAT, 32'h0000_0212, 0, 0);
    `CHK("busy_low", 1'b0, busy_pin)
    wr(`CLCD_A_CMD, 32'h0000_0030, 0, 0);
    @(posedge clk);
    `CHK("busy_high", 1'b1, busy_pin)
    wr(`CLCD_A_DATA, 32'h0000_0011, 1, 0);
    rd(`CLCD_A_STAT, 32'h0000_02B0, 0, 1);
    endt("step");
    wr(`CLCD_A_CMD, 32'h0000_0010, 0, 1);
    rd(`CLCD_A_DATA, 32'h0000_005A, 0, 1);
    rd(`CLCD_A_DATA, 32'h0000_00A5, 0, 1);
    rd(`CLCD_A_STAT, 32'h0000_0212, 0, 0);
    wr(`CLCD_A_CFG, 32'h0000_0001, 0, 0);
    wr(`CLCD_A_DATA, 32'h0000_0033, 0, 1);
    rd(`CLCD_A_STAT, 32'h0000_0211, 0, 0);
    endt("prefetch");
    wr(`CLCD_A_CFG, 32'h0000_00FF, 0, 0);
    rd(`CLCD_A_CFG, 32'h0000_00FF, 0, 0);
    wr(`CLCD_A_CFG, 32'h0000_0000, 0, 0);
    rd(`CLCD_A_CMD, 32'h0, 1, 0);
    wr(`CLCD_A_STAT, 32'h0, 1, 0);
    rd(8'h10, 32'h0, 1, 0);
    wr(`CLCD_A_CMD, 32'h0000_037F, 0, 1);
    wr(`CLCD_A_DATA, 32'h0000_00C3, 0, 1);
    wr(`CLCD_A_CMD, 32'h0000_007F, 0, 1);
    rd(`CLCD_A_DATA, 32'h0000_00C3, 0, 1);
    endt("decode");
    wr(`CLCD_A_CMD, 32'h0000_027F, 0, 1);
    rd(`CLCD_A_STAT, 32'h0000_020F, 0, 0);
    iss <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`CLCD_A_CMD, 32'h0000_027F, 0, 1);
    rd(`CLCD_A_STAT, 32'h0000_003F, 0, 0);
    endt("target");
    h0 = n_hi;
    s0 = n_shift;
    l0 = n_latch;
    repeat (3000) @(posedge clk);
    `CHK("one_line", 1'b0, n_hi != h0)
    `CHK("ext_off", 1'b0, n_shift != s0)
    `CHK("latch_off", 1'b0, n_latch != l0)
    wr(`CLCD_A_CFG, 32'h0000_0040, 0, 0);
    ext_en <= 1'b1;
    iss <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`CLCD_A_STAT, 32'h0000_033F, 0, 0);
    h0 = n_hi;
    s0 = n_shift;
    l0 = n_latch;
    repeat (8000) @(posedge clk);
    `CHK("two_line", 1'b1, n_hi != h0)
    `CHK("ext_on", 1'b1, n_shift != s0)
    `CHK("latch_on", 1'b1, n_latch != l0)
    `CHK("onehot", 1'b0, bad_hot)
    endt("scan");
    stop_test();
  end
endmodule // clcd_top_tb
